/* shared/eps_pkg.sv */
// constants, states and crc helper for the eprom memory-function block
package eps_pkg;

  // command codes; the two write codes are arbitrary values
  localparam logic [7:0]  CMD_READ_DATA    = 8'hf0;
  localparam logic [7:0]  CMD_READ_STATUS  = 8'haa;
  localparam logic [7:0]  CMD_WRITE_DATA   = 8'h3c;
  localparam logic [7:0]  CMD_WRITE_STATUS = 8'h5a;

  // field sizes and address landmarks
  localparam int          DATA_BYTES       = 8192;
  localparam int          STAT_BYTES       = 512;
  localparam int          FIFO_WORDS       = 16;
  localparam logic [15:0] DATA_LAST        = 16'h1fff;
  localparam logic [15:0] STAT_LAST        = 16'h01ff;
  localparam logic [15:0] STAT_GAP_LO      = 16'h0060;
  localparam logic [15:0] STAT_GAP_HI      = 16'h00ff;
  localparam logic [15:0] STAT_REDIR_BASE  = 16'h0100;
  localparam logic [8:0]  STAT_PROT_DATA   = 9'h000;
  localparam logic [8:0]  STAT_PROT_REDIR  = 9'h020;
  localparam logic [15:0] ADDR_STEP        = 16'h0001;

  // byte and crc constants
  localparam logic [7:0]  BYTE_ONES        = 8'hff;
  localparam logic [2:0]  BIT_LAST         = 3'h7;
  localparam logic [2:0]  PAGE_END         = 3'h7;
  localparam logic [15:0] CRC_POLY         = 16'ha001;
  localparam logic [15:0] CRC_CLEAR        = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR_LO   = 4'h1,
    ST_ADDR_HI   = 4'h2,
    ST_RD        = 4'h3,
    ST_CRC_LO    = 4'h4,
    ST_CRC_HI    = 4'h5,
    ST_WR_DATA   = 4'h6,
    ST_WR_PROG   = 4'h7,
    ST_WR_COMMIT = 4'h8,
    ST_WR_VERIFY = 4'h9,
    ST_TAIL      = 4'ha,
    ST_IGNORE    = 4'hb
  } eps_state_type;

  // crc-16 (x16+x15+x2+1), bits taken lsb first
  function automatic logic [15:0] eps_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

/* hdl/eps_mem_func.sv */
// memory-function logic of an add-only eprom: status/data reads, byte programming, outgoing fifo

////////////////////////////////////////////////////////////////////////////////
// byte fifo between the byte producer and the read-slot serializer
module eps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // full and empty come straight from the count
  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= in_data;
  end

  // pointers wrap naturally, so depth must be a power of two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(push);
      rp_r  <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // eps_fifo

////////////////////////////////////////////////////////////////////////////////
// command framing, field access, crc and programming control
module eps_mem_func import eps_pkg::*; #(
  parameter int DATA_SIZE = DATA_BYTES,
  parameter int STAT_SIZE = STAT_BYTES,
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic bus_reset,
  input  wire logic wr_slot,
  input  wire logic wr_bit,
  input  wire logic rd_slot,
  input  wire logic prog_volt,
  output logic      rd_bit,
  output logic      rd_bit_valid,
  output logic      prog_commit,
  output logic      prog_refused,
  output logic      cmd_active
);
  logic [7:0]    data_mem [DATA_SIZE];
  logic [7:0]    stat_mem [STAT_SIZE];
  eps_state_type state_r, state_nxt;
  logic [15:0]   addr_r, addr_nxt;
  logic [15:0]   crc_r, crc_nxt;
  logic [7:0]    scratch_r, scratch_nxt;
  logic          stat_mode_r, stat_mode_nxt;
  logic          wr_mode_r, wr_mode_nxt;
  logic          last_r, last_nxt;
  logic [7:0]    rx_shift_r;
  logic [2:0]    rx_cnt_r;
  logic          pv_s1_r, pv_s2_r, pv_s3_r;
  logic [7:0]    tx_byte_r;
  logic [2:0]    tx_cnt_r;
  logic          tx_loaded_r;
  logic          rd_bit_r, rd_bit_valid_r, commit_r, refuse_r;
  logic [7:0]    old_r;
  logic          ok_r;
  logic          commit_now, refuse_now;
  logic          fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0]    fifo_out_data;

  // erased eprom reads all ones
  initial begin
    for (int i = 0; i < DATA_SIZE; i++) data_mem[i] = BYTE_ONES;
    for (int i = 0; i < STAT_SIZE; i++) stat_mem[i] = BYTE_ONES;
  end

  // implemented status locations; gap and top range are absent
  function automatic logic stat_impl(input logic [15:0] a);
    return (a <= STAT_LAST) && !((a >= STAT_GAP_LO) && (a <= STAT_GAP_HI));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // incoming bits, lsb first
  wire       rx_done = wr_slot && (rx_cnt_r == BIT_LAST);
  wire [7:0] rx_byte = {wr_bit, rx_shift_r[7:1]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_shift_r <= 8'h00;
      rx_cnt_r   <= 3'h0;
    end else if (bus_reset) begin
      rx_cnt_r   <= 3'h0;
    end else if (wr_slot) begin
      rx_shift_r <= rx_byte;
      rx_cnt_r   <= rx_cnt_r + 3'h1;
    end
  end

  // program-voltage detector, two flops then an edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pv_s1_r <= 1'b0;
      pv_s2_r <= 1'b0;
      pv_s3_r <= 1'b0;
    end else begin
      pv_s1_r <= prog_volt;
      pv_s2_r <= pv_s1_r;
      pv_s3_r <= pv_s2_r;
    end
  end
  wire pv_rise = pv_s2_r && !pv_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // field decode; redirection contents steer nothing here, protection bitmap bits gate writes
  wire       data_in    = addr_r <= DATA_LAST;
  wire       field_ok   = stat_mode_r ? (addr_r <= STAT_LAST) : data_in;
  wire [7:0] stat_rd    = stat_impl(addr_r) ? stat_mem[addr_r[8:0]] : BYTE_ONES;
  wire [7:0] data_rd    = data_in ? data_mem[addr_r[12:0]] : BYTE_ONES;
  wire [7:0] field_rd   = stat_mode_r ? stat_rd : data_rd;
  wire [7:0] prot_page  = stat_mode_r ? addr_r[7:0] : addr_r[12:5];
  wire [8:0] prot_base  = stat_mode_r ? STAT_PROT_REDIR : STAT_PROT_DATA;
  wire [8:0] prot_idx   = prot_base | {4'h0, prot_page[7:3]};
  wire       prot_set   = !stat_mem[prot_idx][prot_page[2:0]];
  wire       is_redir   = (addr_r >= STAT_REDIR_BASE) && (addr_r <= STAT_LAST);
  wire       wr_ok      = stat_mode_r ? (stat_impl(addr_r) && !(is_redir && prot_set))
                                      : (data_in && !prot_set);
  wire       field_end  = stat_mode_r ? (addr_r[2:0] == PAGE_END) : (addr_r == DATA_LAST);
  wire       field_last = stat_mode_r ? (addr_r == STAT_LAST) : 1'b1;
  wire       is_stat    = (rx_byte == CMD_READ_STATUS) || (rx_byte == CMD_WRITE_STATUS);
  wire       is_write   = (rx_byte == CMD_WRITE_DATA) || (rx_byte == CMD_WRITE_STATUS);
  wire       is_cmd     = is_stat || is_write || (rx_byte == CMD_READ_DATA);

  // bytes offered to the fifo
  wire push_valid = ((state_r == ST_RD) && field_ok) || (state_r == ST_CRC_LO) || (state_r == ST_CRC_HI)
                    || (state_r == ST_WR_VERIFY) || (state_r == ST_TAIL);
  wire push_ok    = push_valid && fifo_in_ready && !bus_reset;
  wire [7:0] push_data = (state_r == ST_CRC_LO) ? crc_r[7:0] :
                         (state_r == ST_CRC_HI) ? crc_r[15:8] :
                         ((state_r == ST_RD) || (state_r == ST_WR_VERIFY)) ? field_rd : BYTE_ONES;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    crc_nxt       = crc_r;
    scratch_nxt   = scratch_r;
    stat_mode_nxt = stat_mode_r;
    wr_mode_nxt   = wr_mode_r;
    last_nxt      = last_r;
    commit_now    = 1'b0;
    refuse_now    = 1'b0;
    unique case (state_r)
      ST_IDLE: if (rx_done) begin
        crc_nxt       = eps_crc_byte(CRC_CLEAR, rx_byte);
        stat_mode_nxt = is_stat;
        wr_mode_nxt   = is_write;
        state_nxt     = is_cmd ? ST_ADDR_LO : ST_IGNORE;
      end
      ST_ADDR_LO: if (rx_done) begin
        addr_nxt  = {addr_r[15:8], rx_byte};
        crc_nxt   = eps_crc_byte(crc_r, rx_byte);
        state_nxt = ST_ADDR_HI;
      end
      ST_ADDR_HI: if (rx_done) begin
        addr_nxt  = {rx_byte, addr_r[7:0]};
        crc_nxt   = eps_crc_byte(crc_r, rx_byte);
        state_nxt = wr_mode_r ? ST_WR_DATA : ST_RD;
      end
      ST_RD: if (!field_ok) begin
        state_nxt = ST_TAIL;
      end else if (push_ok) begin
        crc_nxt  = eps_crc_byte(crc_r, field_rd);
        addr_nxt = addr_r + ADDR_STEP;
        if (field_end) begin
          last_nxt  = field_last;
          state_nxt = ST_CRC_LO;
        end
      end
      ST_CRC_LO: if (push_ok) state_nxt = ST_CRC_HI;
      ST_CRC_HI: if (push_ok) begin
        if (wr_mode_r) begin
          state_nxt = ST_WR_PROG;
        end else if (last_r) begin
          state_nxt = ST_TAIL;
        end else begin
          crc_nxt   = CRC_CLEAR;
          state_nxt = ST_RD;
        end
      end
      ST_WR_DATA: if (rx_done) begin
        scratch_nxt = rx_byte;
        crc_nxt     = eps_crc_byte(crc_r, rx_byte);
        state_nxt   = ST_CRC_LO;
      end
      ST_WR_PROG: if (pv_rise) state_nxt = ST_WR_COMMIT;
      ST_WR_COMMIT: begin
        commit_now = wr_ok;
        refuse_now = !wr_ok;
        state_nxt  = ST_WR_VERIFY;
      end
      ST_WR_VERIFY: if (push_ok) begin
        addr_nxt  = addr_r + ADDR_STEP;
        crc_nxt   = addr_r + ADDR_STEP;
        state_nxt = ST_WR_DATA;
      end
      ST_TAIL, ST_IGNORE: state_nxt = state_r;
    endcase
    if (bus_reset) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= ST_IDLE;
      addr_r      <= 16'h0000;
      crc_r       <= CRC_CLEAR;
      scratch_r   <= BYTE_ONES;
      stat_mode_r <= 1'b0;
      wr_mode_r   <= 1'b0;
      last_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      crc_r       <= crc_nxt;
      scratch_r   <= scratch_nxt;
      stat_mode_r <= stat_mode_nxt;
      wr_mode_r   <= wr_mode_nxt;
      last_r      <= last_nxt;
    end
  end

  // programming only ands zeros into the cell
  always_ff @(posedge clk) begin
    if (commit_now && !bus_reset) begin
      if (stat_mode_r) stat_mem[addr_r[8:0]] <= stat_mem[addr_r[8:0]] & scratch_r;
      else data_mem[addr_r[12:0]] <= data_mem[addr_r[12:0]] & scratch_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outgoing fifo; a reset pulse drops anything queued
  eps_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (bus_reset),
    .in_valid  (push_valid && !bus_reset),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // read-slot serializer; an empty fifo answers one
  assign fifo_out_ready = rd_slot && !tx_loaded_r && !bus_reset;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte_r      <= BYTE_ONES;
      tx_cnt_r       <= 3'h0;
      tx_loaded_r    <= 1'b0;
      rd_bit_r       <= 1'b1;
      rd_bit_valid_r <= 1'b0;
    end else begin
      rd_bit_valid_r <= rd_slot;
      if (bus_reset) begin
        tx_loaded_r <= 1'b0;
        rd_bit_r    <= 1'b1;
      end else if (rd_slot && tx_loaded_r) begin
        rd_bit_r    <= tx_byte_r[0];
        tx_byte_r   <= tx_byte_r >> 1;
        tx_cnt_r    <= tx_cnt_r + 3'h1;
        tx_loaded_r <= tx_cnt_r != BIT_LAST;
      end else if (rd_slot && fifo_out_valid) begin
        rd_bit_r    <= fifo_out_data[0];
        tx_byte_r   <= fifo_out_data >> 1;
        tx_cnt_r    <= 3'h1;
        tx_loaded_r <= 1'b1;
      end else if (rd_slot) begin
        rd_bit_r    <= 1'b1;
      end
    end
  end

  // commit outcome pulses and verify helpers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      commit_r <= 1'b0;
      refuse_r <= 1'b0;
      old_r    <= BYTE_ONES;
      ok_r     <= 1'b0;
    end else begin
      commit_r <= commit_now;
      refuse_r <= refuse_now;
      if (state_r == ST_WR_COMMIT) old_r <= field_rd;
      if (state_r == ST_WR_COMMIT) ok_r <= wr_ok;
    end
  end

  assign rd_bit       = rd_bit_r;
  assign rd_bit_valid = rd_bit_valid_r;
  assign prog_commit  = commit_r;
  assign prog_refused = refuse_r;
  assign cmd_active   = state_r != ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence sq_rd_take;
    (state_r == ST_RD) && push_ok;
  endsequence
  sequence sq_page_end_take;
    sq_rd_take ##0 field_end;
  endsequence

  a_rd_addr_step: assert property (@(posedge clk) disable iff (!rst_b)
    sq_rd_take |=> addr_r == $past(addr_r) + ADDR_STEP)
    else $error("address counter did not step after a byte");
  a_page_end_crc: assert property (@(posedge clk) disable iff (!rst_b)
    sq_page_end_take ##1 !bus_reset |-> state_r == ST_CRC_LO)
    else $error("no crc after field or page end");
  a_stat_crc_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_CRC_HI) && push_ok && !wr_mode_r && !last_r |=> (crc_r == CRC_CLEAR) && (state_r == ST_RD))
    else $error("crc not cleared for next status page");
  a_tail_ones: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_TAIL) |-> push_data == BYTE_ONES)
    else $error("tail byte not all ones");
  a_reset_abandon: assert property (@(posedge clk) disable iff (!rst_b)
    bus_reset |=> (state_r == ST_IDLE) && !fifo_out_valid && !tx_loaded_r)
    else $error("reset pulse did not abandon command");
  a_verify_and: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_WR_VERIFY) |-> push_data == (ok_r ? (old_r & scratch_r) : old_r))
    else $error("verify byte is not the and of programmed values");
  a_commit_volt: assert property (@(posedge clk) disable iff (!rst_b)
    commit_now |-> $past(pv_rise, 1) && wr_ok)
    else $error("commit without program voltage or with protection");
  a_gap_ones: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_RD) && stat_mode_r && !stat_impl(addr_r) |-> push_data == BYTE_ONES)
    else $error("unimplemented status byte not all ones");
  a_lsb_first: assert property (@(posedge clk) disable iff (!rst_b)
    rd_slot && tx_loaded_r && !bus_reset |=> rd_bit_r == $past(tx_byte_r[0]))
    else $error("outgoing bit order wrong");
endmodule // eps_mem_func

/* tb/eps_master_model.sv */
// behavioural single-wire bus master driving the slot-level ports
module eps_master_model (
  input  wire logic clk,
  input  wire logic rd_bit,
  output logic      bus_reset,
  output logic      wr_slot,
  output logic      wr_bit,
  output logic      rd_slot
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero
  initial begin
    bus_reset = 1'b0;
    wr_slot   = 1'b0;
    wr_bit    = 1'b1;
    rd_slot   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // eight write slots, lsb first
  task automatic send_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #1 wr_slot = 1'b1;
      wr_bit = d[i];
    end
    @(posedge clk) #1 wr_slot = 1'b0;
    wr_bit = ~wr_bit; // a released line never keeps the last bit
  endtask

  // command, low then high address, then time to queue the first byte
  task automatic frame(input logic [7:0] cmd, input logic [15:0] a);
    send_byte(cmd);
    send_byte(a[7:0]);
    send_byte(a[15:8]);
    repeat (3) @(posedge clk);
  endtask

  // eight read slots, each answer taken once settled
  task automatic read_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #1 rd_slot = 1'b1;
      @(posedge clk) #1 rd_slot = 1'b0;
      @(posedge clk) #1 d[i] = rd_bit;
    end
  endtask

  // one-cycle reset pulse, also used to restart a sequence
  task automatic pulse_reset();
    @(posedge clk) #1 bus_reset = 1'b1;
    @(posedge clk) #1 bus_reset = 1'b0;
  endtask
endmodule // eps_master_model

/* tb/testbench.sv */
// self-checking bench for the eprom memory-function block and its fifo
module testbench import eps_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       prog_volt = 1'b0;
  logic       bus_reset, wr_slot, wr_bit, rd_slot;
  logic       rd_bit, rd_bit_valid, prog_commit, prog_refused, cmd_active;
  int         fail_count = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         valid_seen = 0;

  // count answered read slots
  always @(posedge clk) begin
    if (rd_bit_valid === 1'b1) valid_seen++;
  end

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end

  eps_mem_func i_eps_mem_func (.clk(clk), .rst_b(rst_b), .bus_reset(bus_reset), .wr_slot(wr_slot),
    .wr_bit(wr_bit), .rd_slot(rd_slot), .prog_volt(prog_volt), .rd_bit(rd_bit),
    .rd_bit_valid(rd_bit_valid), .prog_commit(prog_commit), .prog_refused(prog_refused),
    .cmd_active(cmd_active));
  eps_master_model i_eps_master_model (.clk(clk), .rd_bit(rd_bit), .bus_reset(bus_reset),
    .wr_slot(wr_slot), .wr_bit(wr_bit), .rd_slot(rd_slot));

  ////////////////////////////////////////////////////////////////////////////////
  // reference crc, lsb first
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one streamed byte, folded into the running crc
  task automatic rd_check(input string what, input logic [7:0] exp, inout logic [15:0] c);
    logic [7:0] b;
    i_eps_master_model.read_byte(b);
    check(what, 16'(b), 16'(exp));
    c = crc8(c, exp);
  endtask

  // crc arrives low byte first, uninverted
  task automatic rd_crc(input string what, input logic [15:0] c);
    logic [7:0] lo, hi;
    i_eps_master_model.read_byte(lo);
    i_eps_master_model.read_byte(hi);
    check(what, {hi, lo}, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one programming pass: crc, program pulse, verify byte
  task automatic t_write(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                         input logic first, input logic ok, input logic [7:0] vb);
    logic [15:0] c;
    logic [7:0]  b;
    c = a; // a continuing pass preloads the new address
    if (first) begin
      i_eps_master_model.pulse_reset();
      c = crc8(crc8(crc8(CRC_CLEAR, cmd), a[7:0]), a[15:8]);
      i_eps_master_model.frame(cmd, a);
    end
    i_eps_master_model.send_byte(d);
    repeat (3) @(posedge clk);
    rd_crc("write crc", crc8(c, d));
    @(posedge clk) #1 prog_volt = 1'b1;
    for (int k = 0; k < 20 && prog_commit !== 1'b1 && prog_refused !== 1'b1; k++) @(posedge clk) #1;
    check("commit", 16'(prog_commit), 16'(ok));
    check("refused", 16'(prog_refused), 16'(!ok));
    prog_volt = 1'b0;
    repeat (2) @(posedge clk); // let the verify byte reach the fifo first
    i_eps_master_model.read_byte(b);
    check("verify", 16'(b), 16'(vb));
  endtask

  task automatic t_unknown();
    logic [15:0] c;
    c = CRC_CLEAR;
    i_eps_master_model.pulse_reset();
    check("idle", 16'(cmd_active), 16'h0000);
    i_eps_master_model.send_byte(8'h00);
    rd_check("unknown cmd", 8'hff, c);
  endtask

  task automatic t_read_data();
    logic [15:0] c;
    c = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_DATA), 8'h1f), 8'h00);
    i_eps_master_model.pulse_reset();
    i_eps_master_model.frame(CMD_READ_DATA, 16'h001f);
    check("busy", 16'(cmd_active), 16'h0001);
    rd_check("byte 1f", 8'hff, c);
    rd_check("byte 20", 8'h00, c);
    rd_check("byte 21", 8'h0f, c);
    rd_check("byte 22", 8'h33, c);
    i_eps_master_model.pulse_reset();
    check("cut off", 16'(cmd_active), 16'h0000);
    rd_check("no crc", 8'hff, c);
    c = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_DATA), 8'hfe), 8'h1f);
    i_eps_master_model.frame(CMD_READ_DATA, 16'h1ffe);
    repeat (40) @(posedge clk); // far side stalls
    rd_check("byte 1ffe", 8'hff, c);
    rd_check("byte 1fff", 8'hff, c);
    rd_crc("data crc", c);
    rd_check("data tail", 8'hff, c);
  endtask

  task automatic t_read_status();
    logic [15:0] c;
    i_eps_master_model.pulse_reset();
    c = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_STATUS), 8'h3e), 8'h00);
    i_eps_master_model.frame(CMD_READ_STATUS, 16'h003e);
    repeat (2) rd_check("stat 03e", 8'hff, c);
    rd_crc("stat crc 1", c);
    c = CRC_CLEAR;
    rd_check("stat 040", 8'hfd, c);
    repeat (7) rd_check("stat 041", 8'hff, c);
    rd_crc("stat crc 2", c);
    rd_check("stat 048", 8'hff, c);
    i_eps_master_model.pulse_reset();
    check("stat cut", 16'(cmd_active), 16'h0000);
    c = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_STATUS), 8'hfe), 8'h01);
    i_eps_master_model.frame(CMD_READ_STATUS, 16'h01fe);
    repeat (2) rd_check("stat 1fe", 8'hff, c);
    rd_crc("stat crc last", c);
    rd_check("stat tail", 8'hff, c);
  endtask

  // reader stalls until the outgoing fifo is full; the byte after a full fifo must not be lost
  task automatic t_fifo();
    logic [15:0] c;
    int          v0;
    c = crc8(crc8(crc8(CRC_CLEAR, CMD_READ_DATA), 8'h12), 8'h00);
    i_eps_master_model.pulse_reset();
    i_eps_master_model.frame(CMD_READ_DATA, 16'h0012);
    repeat (40) @(posedge clk); // far side stalls, fifo fills
    v0 = valid_seen;
    repeat (FIFO_WORDS - 2) rd_check("fifo 012", 8'hff, c);
    rd_check("fifo 020", 8'h00, c);
    rd_check("fifo 021", 8'h0f, c);
    rd_check("fifo past full", 8'h33, c);
    rd_check("fifo 023", 8'hff, c);
    check("read slot answers", 16'(valid_seen - v0), 16'(8 * (FIFO_WORDS + 2)));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    t_unknown();
    t_write(CMD_WRITE_DATA,   16'h0020, 8'ha5, 1'b1, 1'b1, 8'ha5);
    t_write(CMD_WRITE_DATA,   16'h0021, 8'h0f, 1'b0, 1'b1, 8'h0f);
    t_write(CMD_WRITE_DATA,   16'h0020, 8'h5a, 1'b1, 1'b1, 8'h00);
    t_write(CMD_WRITE_STATUS, 16'h0000, 8'hfe, 1'b1, 1'b1, 8'hfe);
    t_write(CMD_WRITE_DATA,   16'h0005, 8'h00, 1'b1, 1'b0, 8'hff);
    t_write(CMD_WRITE_STATUS, 16'h0100, 8'hfd, 1'b1, 1'b1, 8'hfd);
    t_write(CMD_WRITE_STATUS, 16'h0020, 8'hfe, 1'b1, 1'b1, 8'hfe);
    t_write(CMD_WRITE_STATUS, 16'h0100, 8'h00, 1'b1, 1'b0, 8'hfd);
    t_write(CMD_WRITE_STATUS, 16'h0080, 8'h00, 1'b1, 1'b0, 8'hff);
    t_write(CMD_WRITE_STATUS, 16'h0040, 8'hfd, 1'b1, 1'b1, 8'hfd);
    t_write(CMD_WRITE_DATA,   16'h0022, 8'h33, 1'b1, 1'b1, 8'h33);
    t_read_data();
    t_read_status();
    t_fifo();
    test_done();
  end
endmodule // testbench
